// ### core/qrw_cfg.svh
// Constants shared by both ends of the quad read / wrap link.
// Assumes one system clock; included by the package and both ends.
// Functional notes
// - Quad read: address, data on four lanes
// - Mode byte follows address; upper nibble counts
// - Mode bits 5,4 = 10 skip next opcode
// - Other mode values restore normal opcode decoding
// - Host exits skip mode with FFh on lane zero
// - Host releases lanes before first data fall
// - Wrap: start at address, loop within section
// - Wrap command: 77h, 24 dummies, wrap byte
// - Bit 4 low enables wrap; bits 6,5 length
// - Wrap setting holds until next wrap command
// - Wrapping disabled after power on
// - Quad read, wrap command need quad enable
// - Word read: even address, two dummy clocks
// - Word read needs quad enable
// - Octal word read: aligned address, no dummies
// - Octal word read needs quad enable
// - Word read may skip its opcode
// - Octal word read may skip its opcode
// - Mode reset command clears the mode byte
// - Wrap setting also confines word reads
`ifndef QRW_CFG_SVH
`define QRW_CFG_SVH
// Opcodes
`define QRW_OP_QIO      8'hEB
`define QRW_OP_WORD     8'hE7
`define QRW_OP_OCT      8'hE3
`define QRW_OP_WRAP     8'h77
`define QRW_OP_MRST     8'hFF
// Phase lengths in serial clocks
`define QRW_OPC_CLKS    5'h08
`define QRW_ADDR_CLKS   5'h06
`define QRW_BYTE_CLKS   5'h02
`define QRW_WORD_DUMMY  5'h02
`define QRW_OCT_DUMMY   5'h00
`define QRW_QIO_DUMMY   4
// Mode and wrap fields
`define QRW_SKIP_CODE   2'h2
`define QRW_WRAP_RST    3'h1
// Host register word indices and fields
`define QRW_REG_CMD     3'h0
`define QRW_REG_ADDR    3'h1
`define QRW_REG_COUNT   3'h2
`define QRW_REG_STATUS  3'h3
`define QRW_CMD_SKIP    4
`define QRW_CMD_BYTE    8
`define QRW_HALF_DEF    8
`endif

// ### core/qrw_pkg.sv
// Types shared by both ends of the quad read / wrap link.
// Assumes qrw_cfg.svh is on the include path.
`include "qrw_cfg.svh"
package qrw_pkg;
  // Command kinds
  typedef enum logic [2:0] {
    K_QIO  = 3'b000,
    K_WORD = 3'b001,
    K_OCT  = 3'b010,
    K_WRAP = 3'b011,
    K_MRST = 3'b100
  } qrw_kind_type;
  // Flash end phases
  typedef enum logic [3:0] {
    D_IDLE = 4'b0000, D_OPC = 4'b0001, D_ADR = 4'b0010,
    D_MOD  = 4'b0011, D_DUM = 4'b0100, D_DAT = 4'b0101,
    D_WRD  = 4'b0110, D_WRB = 4'b0111, D_IGN = 4'b1000
  } qrw_dev_state_type;
  // Host end phases
  typedef enum logic [3:0] {
    H_IDLE = 4'b0000, H_OPC = 4'b0001, H_ADR = 4'b0010,
    H_MOD  = 4'b0011, H_DUM = 4'b0100, H_DAT = 4'b0101,
    H_END  = 4'b0110, H_GAP = 4'b0111
  } qrw_host_state_type;
  // Dummy clocks per read kind
  function automatic logic [4:0] dummy_clks(qrw_kind_type k,
                                            logic [4:0]   qio);
    case (k)
      K_WORD:  dummy_clks = `QRW_WORD_DUMMY;
      K_OCT:   dummy_clks = `QRW_OCT_DUMMY;
      default: dummy_clks = qio;
    endcase
  endfunction : dummy_clks
endpackage : qrw_pkg

// ### core/qrw_link_if.sv
// Serial link between host controller and flash end.
// Lanes resolve from the two enable sets; undriven lanes pull high.
`timescale 1ns/10ps
interface qrw_link_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] flash_io_out;
  logic [3:0] flash_io_oe;
  logic [3:0] io_lvl;
  // Wire level from enables, pull-up when idle
  assign io_lvl = (host_io_oe & host_io_out)
                | (~host_io_oe & flash_io_oe & flash_io_out)
                | (~host_io_oe & ~flash_io_oe);
  modport host  (output cs_n, sclk, host_io_out, host_io_oe,
                 input io_lvl);
  modport flash (input cs_n, sclk, io_lvl,
                 output flash_io_out, flash_io_oe);
endinterface : qrw_link_if

// ### core/qrw_flash_end.sv
// Flash end: quad reads, continuous mode and burst wrap setting.
// Assumes link pins are asynchronous to sys_clk; array is outside.
`timescale 1ns/10ps
`include "qrw_cfg.svh"
module qrw_flash_end #(
  parameter int unsigned QIO_DUMMY = `QRW_QIO_DUMMY
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Link
  qrw_link_if.flash        link,
  // Status bit and array
  input  wire logic        quad_lane_enable_bit,
  output logic      [23:0] mem_addr,
  input  wire logic [7:0]  mem_data,
  // Volatile settings
  output logic      [2:0]  wrap_setting_bits,
  output logic      [7:0]  continuous_mode_byte
);
  // ==========================================================
  // Checks
  if (QIO_DUMMY < 1 || QIO_DUMMY > 31) begin : g_bad_dummy
    $error("QIO_DUMMY must be 1 to 31");
  end

  // ==========================================================
  // Pin synchronisers
  logic [5:0] sy1;
  logic [5:0] sy2;
  logic [5:0] sy3;
  logic [1:0] stb;
  logic       rise;
  logic       fall;
  logic       sel_on;
  logic       sel_off;
  logic [3:0] lanes;

  // Three stages of {io, sclk, cs_n}
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sy1 <= 6'h01;
      sy2 <= 6'h01;
      sy3 <= 6'h01;
    end
    else
    begin
      sy1 <= {link.io_lvl, link.sclk, link.cs_n};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  // Settled clock and select, updated when stages agree
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      stb <= 2'h1;
    else
      for (int i = 0; i < 2; i++)
        if (sy2[i] == sy3[i])
          stb[i] <= sy3[i];
  end

  // Edge events
  assign rise    = sy2[1] & sy3[1] & ~stb[1];
  assign fall    = ~sy2[1] & ~sy3[1] & stb[1];
  assign sel_on  = ~sy2[0] & ~sy3[0] & stb[0];
  assign sel_off = sy2[0] & sy3[0] & ~stb[0];
  assign lanes   = sy3[5:2];

  // ==========================================================
  // Phase control
  qrw_pkg::qrw_dev_state_type state;
  qrw_pkg::qrw_kind_type      kind;
  qrw_pkg::qrw_kind_type      cont_kind;
  logic [4:0]  cnt;
  logic [6:0]  op_sh;
  logic [23:0] sh;
  logic [7:0]  opcode;
  logic [4:0]  dummy;
  logic        skip_armed;
  logic        nib;
  logic        ones;
  logic [23:0] next_addr;

  assign opcode     = {op_sh, lanes[0]};
  assign dummy      = qrw_pkg::dummy_clks(kind, 5'(QIO_DUMMY));
  assign skip_armed = continuous_mode_byte[5:4] == `QRW_SKIP_CODE;

  // Next byte address, wrapped inside an aligned section
  function automatic logic [23:0] step_addr(logic [23:0] a,
                                            logic [2:0]  w);
    logic [23:0] m;
    m = {18'h0, 6'h3F >> (2'h3 - w[2:1])};
    if (w[0])
      step_addr = a + 24'h1;
    else
      step_addr = (a & ~m) | ((a + 24'h1) & m);
  endfunction : step_addr

  assign next_addr = step_addr(mem_addr, wrap_setting_bits);

  // Phase sequencing on sampled clock edges
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= qrw_pkg::D_IDLE;
      kind  <= qrw_pkg::K_QIO;
      cnt   <= 5'h00;
    end
    else if (sel_off)
      state <= qrw_pkg::D_IDLE;
    else if (sel_on)
    begin
      cnt <= 5'h00;
      if (skip_armed)
      begin
        state <= qrw_pkg::D_ADR;
        kind  <= cont_kind;
      end
      else
        state <= qrw_pkg::D_OPC;
    end
    else if (rise)
    begin
      cnt <= cnt + 5'h01;
      case (state)
        qrw_pkg::D_OPC:
          if (cnt == `QRW_OPC_CLKS - 5'h01)
          begin
            cnt   <= 5'h00;
            state <= qrw_pkg::D_IGN;
            if (quad_lane_enable_bit)
              case (opcode)
                `QRW_OP_QIO:
                begin
                  state <= qrw_pkg::D_ADR;
                  kind  <= qrw_pkg::K_QIO;
                end
                `QRW_OP_WORD:
                begin
                  state <= qrw_pkg::D_ADR;
                  kind  <= qrw_pkg::K_WORD;
                end
                `QRW_OP_OCT:
                begin
                  state <= qrw_pkg::D_ADR;
                  kind  <= qrw_pkg::K_OCT;
                end
                `QRW_OP_WRAP:
                begin
                  state <= qrw_pkg::D_WRD;
                  kind  <= qrw_pkg::K_WRAP;
                end
                default: state <= qrw_pkg::D_IGN;
              endcase
          end
        qrw_pkg::D_ADR:
          if (cnt == `QRW_ADDR_CLKS - 5'h01)
          begin
            cnt   <= 5'h00;
            state <= qrw_pkg::D_MOD;
          end
        qrw_pkg::D_MOD:
          if (cnt == `QRW_BYTE_CLKS - 5'h01)
          begin
            cnt   <= 5'h00;
            state <= (dummy == 5'h00) ? qrw_pkg::D_DAT
                                      : qrw_pkg::D_DUM;
          end
        qrw_pkg::D_DUM:
          if (cnt == dummy - 5'h01)
            state <= qrw_pkg::D_DAT;
        qrw_pkg::D_WRD:
          if (cnt == `QRW_ADDR_CLKS - 5'h01)
          begin
            cnt   <= 5'h00;
            state <= qrw_pkg::D_WRB;
          end
        qrw_pkg::D_WRB:
          if (cnt == `QRW_BYTE_CLKS - 5'h01)
            state <= qrw_pkg::D_IGN;
        default: cnt <= 5'h00;
      endcase
    end
  end

  // Input shifters, lane zero all-ones tracker since select
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_sh <= 7'h00;
      sh    <= 24'h0;
      ones  <= 1'b0;
    end
    else if (sel_on)
      ones <= 1'b1;
    else if (rise)
    begin
      ones <= ones & lanes[0];
      if (state == qrw_pkg::D_OPC)
        op_sh <= opcode[6:0];
      else
        sh <= {sh[19:0], lanes};
    end
  end

  // ==========================================================
  // Settings
  // Mode byte after the address, cleared by the reset command
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      continuous_mode_byte <= 8'h00;
      cont_kind            <= qrw_pkg::K_QIO;
    end
    else if (rise && state == qrw_pkg::D_OPC &&
             cnt == `QRW_OPC_CLKS - 5'h01 &&
             opcode == `QRW_OP_MRST)
      continuous_mode_byte <= 8'h00;
    else if (rise && state == qrw_pkg::D_MOD &&
             cnt == `QRW_BYTE_CLKS - 5'h01)
    begin
      // Lane zero high all through a skipped frame resets the mode
      if (ones && lanes[0])
        continuous_mode_byte <= 8'h00;
      else
        continuous_mode_byte <= {sh[3:0], lanes};
      cont_kind            <= kind;
    end
  end

  // Wrap bits 6 to 4 from the wrap byte
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      wrap_setting_bits <= `QRW_WRAP_RST;
    else if (rise && state == qrw_pkg::D_WRB &&
             cnt == `QRW_BYTE_CLKS - 5'h01)
      wrap_setting_bits <= sh[2:0];
  end

  // ==========================================================
  // Data output
  // Array address: start address, then step after each byte
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      mem_addr <= 24'h0;
    else if (rise && state == qrw_pkg::D_ADR &&
             cnt == `QRW_ADDR_CLKS - 5'h01)
      mem_addr <= {sh[19:0], lanes};
    else if (fall && state == qrw_pkg::D_DAT && nib)
      mem_addr <= next_addr;
  end

  // Nibbles out on falling edges, high nibble first
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link.flash_io_out <= 4'h0;
      link.flash_io_oe  <= 4'h0;
      nib               <= 1'b0;
    end
    else if (sel_off || sel_on)
    begin
      link.flash_io_oe <= 4'h0;
      nib              <= 1'b0;
    end
    else if (fall && state == qrw_pkg::D_DAT)
    begin
      link.flash_io_oe  <= 4'hF;
      link.flash_io_out <= nib ? mem_data[3:0] : mem_data[7:4];
      nib               <= ~nib;
    end
  end
endmodule : qrw_flash_end

// ### core/qrw_host_end.sv
// Host end: issues quad reads, wrap and mode reset commands.
// Assumes an Avalon-MM master on sys_clk; link lanes from the flash.
`timescale 1ns/10ps
`include "qrw_cfg.svh"
module qrw_host_end #(
  parameter int unsigned HALF      = `QRW_HALF_DEF,
  parameter int unsigned QIO_DUMMY = `QRW_QIO_DUMMY
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Link
  qrw_link_if.host         link
);
  // ==========================================================
  // Checks
  if (HALF < 8 || HALF > 255 || QIO_DUMMY < 1 || QIO_DUMMY > 31)
  begin : g_bad_param
    $error("HALF must be 8 to 255, QIO_DUMMY 1 to 31");
  end

  // ==========================================================
  // Registers
  qrw_pkg::qrw_host_state_type state;
  qrw_pkg::qrw_kind_type       kind;
  logic        skip;
  logic [7:0]  mbyte;
  logic [23:0] addr;
  logic [7:0]  count;
  logic [7:0]  rx_byte;
  logic [7:0]  rx_cnt;
  logic        wr_take;
  logic        start;
  logic [2:0]  idx;

  assign idx     = avs_address[4:2];
  assign wr_take = avs_write & ~avs_waitrequest;
  assign start   = wr_take && idx == `QRW_REG_CMD &&
                   state == qrw_pkg::H_IDLE;

  // One wait cycle, then read data and write take effect
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      case (idx)
        `QRW_REG_CMD:    avs_readdata <= {16'h0, mbyte, 3'h0, skip,
                                          1'b0, kind};
        `QRW_REG_ADDR:   avs_readdata <= {8'h0, addr};
        `QRW_REG_COUNT:  avs_readdata <= {24'h0, count};
        `QRW_REG_STATUS: avs_readdata <= {8'h0, rx_cnt, rx_byte,
                             7'h0, state != qrw_pkg::H_IDLE};
        default:         avs_readdata <= 32'h0;
      endcase
    end
  end

  // Software settings, frozen while busy
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      kind  <= qrw_pkg::K_QIO;
      skip  <= 1'b0;
      mbyte <= 8'h00;
      addr  <= 24'h0;
      count <= 8'h01;
    end
    else if (wr_take && state == qrw_pkg::H_IDLE)
      case (idx)
        `QRW_REG_CMD:
        begin
          kind  <= qrw_pkg::qrw_kind_type'(avs_writedata[2:0]);
          skip  <= avs_writedata[`QRW_CMD_SKIP];
          mbyte <= avs_writedata[`QRW_CMD_BYTE +: 8];
        end
        `QRW_REG_ADDR:  addr  <= avs_writedata[23:0];
        `QRW_REG_COUNT: count <= avs_writedata[7:0];
        default:        count <= count;
      endcase
  end

  // ==========================================================
  // Link timing
  logic [7:0]  div;
  logic        tick;
  logic [3:0]  io_s1;
  logic [3:0]  io_s2;
  logic [3:0]  io_s3;
  logic [4:0]  cnt;
  logic [4:0]  dummy;
  logic [31:0] sh;
  logic [3:0]  rx_hi;
  logic        lead;
  logic        nib;
  logic [7:0]  opc;
  qrw_pkg::qrw_kind_type new_kind;

  assign new_kind = qrw_pkg::qrw_kind_type'(avs_writedata[2:0]);
  assign tick  = (div == 8'(HALF - 1)) && state != qrw_pkg::H_IDLE;
  assign dummy = qrw_pkg::dummy_clks(kind, 5'(QIO_DUMMY));

  // Opcode of the command being written
  always_comb
  begin
    case (new_kind)
      qrw_pkg::K_WORD: opc = `QRW_OP_WORD;
      qrw_pkg::K_OCT:  opc = `QRW_OP_OCT;
      qrw_pkg::K_WRAP: opc = `QRW_OP_WRAP;
      qrw_pkg::K_MRST: opc = `QRW_OP_MRST;
      default:         opc = `QRW_OP_QIO;
    endcase
  end

  // Half-period divider and lane synchroniser
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div   <= 8'h00;
      io_s1 <= 4'hF;
      io_s2 <= 4'hF;
      io_s3 <= 4'hF;
    end
    else
    begin
      div   <= (tick || state == qrw_pkg::H_IDLE) ? 8'h00
                                                  : div + 8'h01;
      io_s1 <= link.io_lvl;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
    end
  end

  // Frame sequencing: drive on falls, sample on rises
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state            <= qrw_pkg::H_IDLE;
      link.cs_n        <= 1'b1;
      link.sclk        <= 1'b0;
      link.host_io_out <= 4'h0;
      link.host_io_oe  <= 4'h0;
      sh <= 32'h0; cnt <= 5'h00; lead <= 1'b0; nib <= 1'b0;
      rx_hi <= 4'h0; rx_byte <= 8'h00; rx_cnt <= 8'h00;
    end
    else if (start)
    begin
      link.cs_n <= 1'b0;
      lead <= 1'b1; cnt <= 5'h00; nib <= 1'b0; rx_cnt <= 8'h00;
      if (avs_writedata[`QRW_CMD_SKIP] && new_kind <= qrw_pkg::K_OCT)
      begin
        state <= qrw_pkg::H_ADR;
        sh    <= {addr, avs_writedata[`QRW_CMD_BYTE +: 8]};
      end
      else
      begin
        state <= qrw_pkg::H_OPC;
        sh    <= {opc, 24'h0};
      end
    end
    else if (tick)
    begin
      if (state == qrw_pkg::H_GAP)
        state <= qrw_pkg::H_IDLE;
      else if (link.sclk || lead)
      begin
        link.sclk <= 1'b0;
        lead      <= 1'b0;
        case (state)
          qrw_pkg::H_OPC:
          begin
            link.host_io_out <= {3'h0, sh[31]};
            link.host_io_oe  <= 4'h1;
            sh               <= {sh[30:0], 1'b0};
          end
          qrw_pkg::H_ADR, qrw_pkg::H_MOD:
          begin
            link.host_io_out <= sh[31:28];
            link.host_io_oe  <= 4'hF;
            sh               <= {sh[27:0], 4'h0};
          end
          qrw_pkg::H_END:
          begin
            link.cs_n       <= 1'b1;
            link.host_io_oe <= 4'h0;
            state           <= qrw_pkg::H_GAP;
          end
          default: lead <= 1'b0;
        endcase
      end
      else
      begin
        link.sclk <= 1'b1;
        cnt       <= cnt + 5'h01;
        case (state)
          qrw_pkg::H_OPC:
            if (cnt == `QRW_OPC_CLKS - 5'h01)
            begin
              cnt <= 5'h00;
              if (kind == qrw_pkg::K_MRST)
                state <= qrw_pkg::H_END;
              else
              begin
                state <= qrw_pkg::H_ADR;
                sh    <= {(kind == qrw_pkg::K_WRAP) ? 24'h0 : addr,
                          mbyte};
              end
            end
          qrw_pkg::H_ADR:
            if (cnt == `QRW_ADDR_CLKS - 5'h01)
            begin
              cnt   <= 5'h00;
              state <= qrw_pkg::H_MOD;
            end
          qrw_pkg::H_MOD:
            if (cnt == `QRW_BYTE_CLKS - 5'h01)
            begin
              cnt <= 5'h00;
              if (kind == qrw_pkg::K_WRAP)
                state <= qrw_pkg::H_END;
              else
              begin
                link.host_io_oe <= 4'h0;
                state <= (dummy == 5'h00) ? qrw_pkg::H_DAT
                                          : qrw_pkg::H_DUM;
              end
            end
          qrw_pkg::H_DUM:
            if (cnt == dummy - 5'h01)
              state <= qrw_pkg::H_DAT;
          qrw_pkg::H_DAT:
          begin
            nib <= ~nib;
            if (!nib)
              rx_hi <= io_s3;
            else
            begin
              rx_byte <= {rx_hi, io_s3};
              rx_cnt  <= rx_cnt + 8'h01;
              if (rx_cnt + 8'h01 == count)
                state <= qrw_pkg::H_END;
            end
          end
          default: cnt <= 5'h00;
        endcase
      end
    end
  end
endmodule : qrw_host_end

// ### verification/qrw_link_monitor.sv
// Checker for the quad link and the flash end's volatile settings.
// Assumes one clock; tb instantiates it beside the link interface.
`timescale 1ns/10ps
module qrw_link_monitor (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // Link
  input wire logic        cs_n,
  input wire logic        sclk,
  input wire logic [3:0]  host_io_oe,
  input wire logic [3:0]  flash_io_oe,
  // Flash end
  input wire logic        quad_lane_enable_bit,
  input wire logic [23:0] mem_addr,
  input wire logic [2:0]  wrap_setting_bits,
  input wire logic [7:0]  continuous_mode_byte
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [23:0] lo;
  logic        step;
  // Section mask and data-phase address step
  assign lo = (24'h8 << wrap_setting_bits[2:1]) - 24'h1;
  assign step = !cs_n && (flash_io_oe != 4'h0);
  // ==========================================================
  // Assertions
  AST_NO_CONTENTION: assert property (
    (host_io_oe & flash_io_oe) == 4'h0)
    else $error("Both ends drive one lane");
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("Serial clock runs outside a frame");
  AST_FLASH_QUIET: assert property (cs_n [*8] |-> flash_io_oe == 4'h0)
    else $error("Flash drives after deselect");
  AST_LANE_SETS: assert property (host_io_oe inside {4'h0, 4'h1, 4'hF}
    && flash_io_oe inside {4'h0, 4'hF})
    else $error("Lane enables not one or four lanes");
  AST_WRAP_NEEDS_QE: assert property ($changed(wrap_setting_bits)
    |-> quad_lane_enable_bit)
    else $error("Wrap setting changed without quad enable");
  AST_MODE_NEEDS_QE: assert property ($changed(continuous_mode_byte)
    && continuous_mode_byte != 8'h00 |-> quad_lane_enable_bit)
    else $error("Mode byte stored without quad enable");
  AST_REFUSED_SILENT: assert property (!quad_lane_enable_bit [*8]
    |-> flash_io_oe == 4'h0)
    else $error("Flash drives with quad enable low");
  AST_LINEAR_STEP: assert property (step && $past(step)
    && $changed(mem_addr) && wrap_setting_bits[0]
    |-> mem_addr == $past(mem_addr) + 24'h1)
    else $error("Linear read skipped an address");
  AST_WRAP_STEP: assert property (step && $past(step)
    && $changed(mem_addr) && !wrap_setting_bits[0]
    |-> (mem_addr & ~lo) == ($past(mem_addr) & ~lo)
    && ((mem_addr - $past(mem_addr)) & lo) == 24'h1)
    else $error("Wrapped read left its section");
  // Main scenarios seen
  COV_DRIVE: cover property ($rose(flash_io_oe[0]));
  COV_WRAP: cover property (step && !wrap_setting_bits[0]);
  COV_SKIP: cover property (continuous_mode_byte[5:4] == 2'h2);
endmodule : qrw_link_monitor

// ### verification/tb.sv
// Testbench: host end and flash end joined by the link interface.
// Assumes the core files are compiled first; array is a bench function.
`timescale 1ns/10ps
module tb;
  logic        sys_clk       = 1'b0;
  logic        reset_n       = 1'b0;
  logic [4:0]  avs_address   = 5'h00;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        qe            = 1'b1;
  logic [23:0] mem_addr;
  logic [7:0]  mem_data;
  logic [2:0]  wrap_setting_bits;
  logic [7:0]  continuous_mode_byte;
  logic [15:0] seed          = 16'h003C;
  logic [2:0]  wexp          = 3'h1;
  int          errors        = 0;
  int          n_compared    = 0;
  int          cycles        = 0;
  qrw_link_if link ();
  qrw_host_end #(.HALF(8), .QIO_DUMMY(3)) i_qrw_host_end (
    .sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link));
  qrw_flash_end #(.QIO_DUMMY(3)) i_qrw_flash_end (
    .sys_clk(sys_clk), .reset_n(reset_n), .link(link),
    .quad_lane_enable_bit(qe), .mem_addr(mem_addr), .mem_data(mem_data),
    .wrap_setting_bits(wrap_setting_bits),
    .continuous_mode_byte(continuous_mode_byte));
  qrw_link_monitor i_qrw_link_monitor (
    .sys_clk(sys_clk), .reset_n(reset_n), .cs_n(link.cs_n),
    .sclk(link.sclk), .host_io_oe(link.host_io_oe),
    .flash_io_oe(link.flash_io_oe), .quad_lane_enable_bit(qe),
    .mem_addr(mem_addr), .wrap_setting_bits(wrap_setting_bits),
    .continuous_mode_byte(continuous_mode_byte));
  // ==========================================================
  // Array contents, clock and timeout
  function automatic logic [7:0] arr(input logic [23:0] a);
    arr = a[7:0] ^ {a[11:8], a[19:16]};
  endfunction : arr
  assign mem_data = arr(mem_addr);
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      errors++;
      $display("MISMATCH %0t timeout", $time);
      end_sim();
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] last(input logic [23:0] a,
                                      input logic [7:0] c);
    logic [23:0] lo;
    lo = wexp[0] ? 24'hFFFFFF : (24'h8 << wexp[2:1]) - 24'h1;
    last = qe ? arr((a & ~lo) | ((a + 24'(c) - 24'h1) & lo)) : 8'hFF;
  endfunction : last
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    if (got !== exp)
      errors++;
  endtask : chk
  task automatic av(input logic wr, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk(32'(n), 32'h2);
  endtask : av
  task automatic cmd(input logic [2:0] k, input logic sk,
                     input logic [7:0] m, input logic [23:0] a,
                     input logic [7:0] c, output logic [31:0] st);
    int n;
    if (k == 3'h1)
      a[0] = 1'b0;
    if (k == 3'h2)
      a[3:0] = 4'h0;
    av(1'b1, 5'h04, {8'h0, a}, st);
    av(1'b1, 5'h08, {24'h0, c}, st);
    av(1'b1, 5'h00, {16'h0, m, 3'h0, sk, 1'b0, k}, st);
    n = 0;
    do
    begin
      av(1'b0, 5'h0C, 32'h0, st);
      n++;
    end while (st[0] !== 1'b0 && n < 3000);
    chk(32'(st[0]), 32'h0);
    if (k < 3'h3)
      chk({16'h0, st[23:8]}, {16'h0, c, last(a, c)});
  endtask : cmd
  task automatic wrap(input logic [7:0] wb);
    logic [31:0] st;
    cmd(3'h3, 1'b0, wb, 24'h0, 8'h1, st);
    if (qe)
      wexp = wb[6:4];
    chk(32'(wrap_setting_bits), 32'(wexp));
  endtask : wrap
  task automatic end_sim();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  // ==========================================================
  // Main sequence
  initial
  begin
    logic [31:0] st;
    logic [7:0]  m;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk(32'(wrap_setting_bits), 32'h1);
    chk(32'(continuous_mode_byte), 32'h0);
    av(1'b0, 5'h08, 32'h0, st);
    chk(st, 32'h1);
    av(1'b0, 5'h1C, 32'h0, st);
    chk(st, 32'h0);
    // Linear reads of each kind
    for (int i = 0; i < 9; i++)
    begin
      seed = lfsr(seed);
      cmd(3'(i % 3), 1'b0, 8'h0, {seed, seed[7:0]},
          8'(seed[4:0]) + 8'h1, st);
    end
    // Each section length, crossing its end
    for (int l = 0; l < 4; l++)
    begin
      seed = lfsr(seed);
      wrap({seed[7], 2'(l), 1'b0, seed[3:0]});
      for (int k = 0; k < 3; k++)
        cmd(3'(k), 1'b0, 8'h0, {seed[7:0], seed},
            (8'h8 << l) + 8'h3, st);
    end
    wrap(8'h7F);
    cmd(3'h0, 1'b0, 8'h0, 24'h0000F8, 8'h14, st);
    // Opcode skipping per kind, then leaving it
    for (int k = 0; k < 3; k++)
    begin
      seed = lfsr(seed);
      m = {seed[7:6], 2'h2, seed[3:0]};
      cmd(3'(k), 1'b0, m, {seed, 8'h10}, 8'h3, st);
      chk(32'(continuous_mode_byte), 32'({m[7:4], 4'hF}));
      cmd(3'(k), 1'b1, {m[7:6], 2'(k) | 2'(k >> 1), 4'h5},
          {8'h3, seed}, 8'h5, st);
      cmd(3'(k), 1'b0, 8'h0, {seed[7:0], seed}, 8'h2, st);
    end
    // Mode reset command clears skipping
    cmd(3'h0, 1'b0, 8'h20, 24'h001234, 8'h2, st);
    cmd(3'h4, 1'b0, 8'h0, 24'h0, 8'h1, st);
    chk(32'(continuous_mode_byte), 32'h0);
    cmd(3'h1, 1'b0, 8'h0, 24'h004320, 8'h3, st);
    // Quad enable low: reads and wrap refused
    qe <= 1'b0;
    @(posedge sys_clk);
    for (int k = 0; k < 3; k++)
      cmd(3'(k), 1'b0, 8'h0, 24'h000040, 8'h2, st);
    wrap(8'h00);
    qe <= 1'b1;
    end_sim();
  end
endmodule : tb
